// >>> core/packet_length_framer.sv
// packet framer: fifo, tx framing, rx deframing, checksum and host interrupt mapping
// Notes on behaviour
// [R1] packet handler runs only in mode 10/11
// [R2] format 0 is fixed, length from limit
// [R3] fixed length counts address and data bytes
// [R4] order: preamble, start, payload, checksum
// [R5] framing bytes added on tx, stripped rx
// [R6] format 1: length byte after start pattern
// [R7] first fifo byte counts following payload bytes
// [R8] rx length byte above limit discards packet
// [R9] limit 65..127 with format 1 is extended
// [R10] preamble size 10 gives 3, 11 gives 4
// [R11] checksum only when checksum enable set
// [R12] pass flag cleared by writing one
// [R13] depth select 11 gives 64 byte fifo
// [R14] rx source 11: line b is level event
// [R15] rx source 00: line b is checksum good
// [R16] tx source 0: start at threshold fill
// [R17] tx source 0: line a when count low
// [R18] host drains rx fifo before full
// [R19] host refills tx fifo in time
// [R20] tx line1 source 1: last bit event
// [R21] host holds tx one bit after last
// [R22] host leaves one byte on partial reads
// [R23] 16-bit checksum appended after payload
// [R24] checksum fail clears fifo unless override
// [R25] rx counter from length ends payload
`timescale 1ns/100ps
module packet_length_framer #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  input  wire pkt_framer_pkg::cfg_t cfg_in,
  input  wire logic                 tx_mode_in,
  input  wire logic                 pass_clear_in,
  input  wire logic                 host_wr_in,
  input  wire logic [7:0]           host_wr_data_in,
  input  wire logic                 host_rd_in,
  output logic      [7:0]           host_rd_data_out,
  output logic      [6:0]           fifo_count_out,
  input  wire logic                 tx_ready_in,
  output logic                      tx_valid_out,
  output logic      [7:0]           tx_byte_out,
  input  wire logic                 rx_start_in,
  input  wire logic                 rx_valid_in,
  input  wire logic [7:0]           rx_byte_in,
  output logic                      checksum_pass_flag_out,
  output logic                      host_irq_line_a_out,
  output logic                      host_irq_line_b_out
);
  if (FIFO_DEPTH != pkt_framer_pkg::FIFO_MAX)
  begin : g_depth_chk
    $error("FIFO_DEPTH must be 64");
  end

  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC_HI, TX_SYNC_LO, TX_PAY, TX_CRC_HI, TX_CRC_LO} tx_state_t;
  typedef enum logic [2:0] {RX_HUNT, RX_LEN, RX_PAY, RX_CRC_HI, RX_CRC_LO} rx_state_t;

  pkt_framer_pkg::cfg_t c;
  logic [7:0]  mem [FIFO_DEPTH];
  logic [5:0]  wp_reg, rp_reg;
  logic [6:0]  cnt_reg, size, thr, len_max, tx_left, rx_left;
  logic        pkt_on, tx_on, rx_on, ext_mode, full, empty;
  logic        wr_en, push_ok, rd_en, slot, tx_pop, tx_go, rx_push, clr;
  logic        chk_done, crc_ok, fin_plain, drain;
  logic [7:0]  wr_d, head;
  tx_state_t   tx_state_reg;
  rx_state_t   rx_state_reg;
  logic [6:0]  tcnt_reg, rcnt_reg;
  logic [15:0] tcrc_reg, rcrc_reg;
  logic [7:0]  rhi_reg;
  logic        first_reg, last_reg, good_reg, rdy_reg;
  logic        irq_a_next, irq_b_next;

  assign c        = cfg_in;
  assign pkt_on   = c.op_mode_select[1] == pkt_framer_pkg::MODE_PKT_BIT; // R1
  assign tx_on    = pkt_on && tx_mode_in;
  assign rx_on    = pkt_on && !tx_mode_in;
  assign size     = pkt_framer_pkg::depth_bytes(c.queue_depth_select); // R13
  assign full     = cnt_reg >= size;
  assign empty    = cnt_reg == 7'h00;
  assign thr      = {1'b0, c.queue_level_threshold};
  assign head     = mem[rp_reg];
  assign ext_mode = (c.length_format_select == pkt_framer_pkg::FMT_VAR) && // R9
                    (c.payload_length_limit >= pkt_framer_pkg::EXT_LEN_MIN) &&
                    (c.payload_length_limit <= pkt_framer_pkg::EXT_LEN_MAX);
  // extended mode streams through the fifo, otherwise the whole packet must fit
  assign len_max  = ext_mode ? c.payload_length_limit : // R8 R9
                    pkt_framer_pkg::min7(c.payload_length_limit, 7'(size - 7'h01));

  assign slot    = !tx_valid_out || tx_ready_in;
  assign tx_pop  = (tx_state_reg == TX_PAY) && slot && !empty;
  assign tx_go   = !empty && (c.tx_line0_source != pkt_framer_pkg::TX0_LEVEL || cnt_reg >= thr); // R16
  assign tx_left = first_reg ? head[6:0] : 7'(tcnt_reg - 7'h01); // R7

  assign rx_push = rx_on && rx_valid_in && (rx_state_reg == RX_PAY || // R5
                   (rx_state_reg == RX_LEN && rx_byte_in <= {1'b0, len_max})); // R8
  assign rx_left  = (rx_state_reg == RX_LEN) ? rx_byte_in[6:0] : 7'(rcnt_reg - 7'h01); // R25
  assign chk_done = rx_on && rx_valid_in && rx_state_reg == RX_CRC_LO;
  assign crc_ok   = {rhi_reg, rx_byte_in} == rcrc_reg;
  assign clr      = chk_done && !crc_ok && !c.crc_autoclear_override; // R24
  assign fin_plain = rx_push && rx_left == 7'h00 && !c.checksum_enable;
  assign drain    = !tx_mode_in && host_rd_in && cnt_reg == 7'h01;

  always_comb
  begin
    wr_en   = tx_mode_in ? host_wr_in : rx_push;
    wr_d    = tx_mode_in ? host_wr_data_in : rx_byte_in;
    push_ok = wr_en && !full; // R18 R19
    rd_en   = (tx_mode_in ? tx_pop : host_rd_in) && !empty;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (push_ok)
    begin
      mem[wp_reg] <= wr_d;
    end
  end

  // fifo pointers and fill count
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wp_reg  <= 6'h00;
      rp_reg  <= 6'h00;
      cnt_reg <= 7'h00;
    end
    else if (clr)
    begin
      wp_reg  <= 6'h00; // R24
      rp_reg  <= 6'h00;
      cnt_reg <= 7'h00;
    end
    else
    begin
      if (push_ok)
      begin
        wp_reg <= 6'(wp_reg + 6'h01);
      end
      if (rd_en)
      begin
        rp_reg <= 6'(rp_reg + 6'h01);
      end
      cnt_reg <= 7'(cnt_reg + 7'(push_ok) - 7'(rd_en));
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      host_rd_data_out <= 8'h00;
    end
    else if (!tx_mode_in && host_rd_in && !empty)
    begin
      host_rd_data_out <= head;
    end
  end

  // transmit framer; leaving transmit mode cuts the frame at once
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_state_reg <= TX_IDLE;
      tx_valid_out <= 1'b0;
      tx_byte_out  <= 8'h00;
      tcnt_reg     <= 7'h00;
      tcrc_reg     <= pkt_framer_pkg::CRC_INIT;
      first_reg    <= 1'b0;
      last_reg     <= 1'b0;
    end
    else if (!tx_on)
    begin
      tx_state_reg <= TX_IDLE; // R1
      tx_valid_out <= 1'b0;
    end
    else
    begin
      if (slot)
      begin
        tx_valid_out <= 1'b0;
      end
      case (tx_state_reg)
        TX_IDLE:
          if (tx_go)
          begin
            tx_state_reg <= TX_PRE; // R16
            tcnt_reg     <= 7'(c.preamble_size); // R10
            tcrc_reg     <= pkt_framer_pkg::CRC_INIT;
            last_reg     <= 1'b0;
          end
        TX_PRE:
          if (slot)
          begin
            tx_byte_out  <= pkt_framer_pkg::PREAMBLE_BYTE; // R4 R5
            tx_valid_out <= 1'b1;
            tcnt_reg     <= 7'(tcnt_reg - 7'h01);
            if (tcnt_reg == 7'h00)
            begin
              tx_state_reg <= TX_SYNC_HI;
            end
          end
        TX_SYNC_HI:
          if (slot)
          begin
            tx_byte_out  <= pkt_framer_pkg::SYNC_WORD[15:8]; // R4
            tx_valid_out <= 1'b1;
            tx_state_reg <= TX_SYNC_LO;
          end
        TX_SYNC_LO:
          if (slot)
          begin
            tx_byte_out  <= pkt_framer_pkg::SYNC_WORD[7:0];
            tx_valid_out <= 1'b1;
            tx_state_reg <= TX_PAY;
            first_reg    <= c.length_format_select == pkt_framer_pkg::FMT_VAR; // R6
            tcnt_reg     <= pkt_framer_pkg::min7(c.payload_length_limit, size); // R2 R3
          end
        TX_PAY:
          if (slot)
          begin
            if (empty)
            begin
              tx_state_reg <= TX_IDLE; // R19
            end
            else
            begin
              tx_byte_out  <= head;
              tx_valid_out <= 1'b1;
              tcrc_reg     <= pkt_framer_pkg::crc16_byte(tcrc_reg, head); // R23
              first_reg    <= 1'b0;
              tcnt_reg     <= tx_left; // R7
              if (tx_left == 7'h00)
              begin
                tx_state_reg <= c.checksum_enable ? TX_CRC_HI : TX_IDLE; // R11
                last_reg     <= !c.checksum_enable; // R20
              end
            end
          end
        TX_CRC_HI:
          if (slot)
          begin
            tx_byte_out  <= tcrc_reg[15:8]; // R23
            tx_valid_out <= 1'b1;
            tx_state_reg <= TX_CRC_LO;
          end
        TX_CRC_LO:
          if (slot)
          begin
            tx_byte_out  <= tcrc_reg[7:0];
            tx_valid_out <= 1'b1;
            tx_state_reg <= TX_IDLE;
            last_reg     <= 1'b1; // R20
          end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // receive deframer; preamble, start pattern and checksum never reach the fifo
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_state_reg <= RX_HUNT;
      rcnt_reg     <= 7'h00;
      rcrc_reg     <= pkt_framer_pkg::CRC_INIT;
      rhi_reg      <= 8'h00;
    end
    else if (!rx_on)
    begin
      rx_state_reg <= RX_HUNT;
    end
    else
    begin
      case (rx_state_reg)
        RX_HUNT:
          if (rx_start_in)
          begin
            rcrc_reg     <= pkt_framer_pkg::CRC_INIT;
            rcnt_reg     <= pkt_framer_pkg::min7(c.payload_length_limit, size); // R2 R3
            rx_state_reg <= (c.length_format_select == pkt_framer_pkg::FMT_VAR) ? RX_LEN : RX_PAY; // R6
          end
        RX_LEN, RX_PAY:
          if (rx_push)
          begin
            rcrc_reg <= pkt_framer_pkg::crc16_byte(rcrc_reg, rx_byte_in);
            rcnt_reg <= rx_left; // R25
            if (rx_left == 7'h00)
            begin
              rx_state_reg <= c.checksum_enable ? RX_CRC_HI : RX_HUNT; // R11
            end
            else
            begin
              rx_state_reg <= RX_PAY;
            end
          end
          else if (rx_valid_in)
          begin
            rx_state_reg <= RX_HUNT; // R8
          end
        RX_CRC_HI:
          if (rx_valid_in)
          begin
            rhi_reg      <= rx_byte_in;
            rx_state_reg <= RX_CRC_LO;
          end
        RX_CRC_LO:
          if (rx_valid_in)
          begin
            rx_state_reg <= RX_HUNT;
          end
        default:
          rx_state_reg <= RX_HUNT;
      endcase
    end
  end

  // receive events; a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      good_reg               <= 1'b0;
      rdy_reg                <= 1'b0;
      checksum_pass_flag_out <= 1'b0;
    end
    else
    begin
      if (chk_done && crc_ok)
      begin
        good_reg <= 1'b1;
      end
      else if (drain || (rx_on && rx_start_in))
      begin
        good_reg <= 1'b0;
      end
      if ((chk_done && (crc_ok || c.crc_autoclear_override)) || fin_plain)
      begin
        rdy_reg <= 1'b1; // R24
      end
      else if (drain || (rx_on && rx_start_in))
      begin
        rdy_reg <= 1'b0;
      end
      if (chk_done && crc_ok)
      begin
        checksum_pass_flag_out <= 1'b1;
      end
      else if (pass_clear_in)
      begin
        checksum_pass_flag_out <= 1'b0; // R12
      end
    end
  end

  always_comb
  begin
    irq_a_next = 1'b0;
    irq_b_next = 1'b0;
    if (tx_on)
    begin
      irq_a_next = (c.tx_line0_source == pkt_framer_pkg::TX0_LEVEL) ? (cnt_reg <= thr) : !empty; // R17
      irq_b_next = (c.tx_line1_source == pkt_framer_pkg::TX1_LAST) ? last_reg : full; // R20
    end
    else if (rx_on)
    begin
      irq_a_next = rdy_reg;
      case (c.rx_line1_source)
        pkt_framer_pkg::RX1_CRC_OK: irq_b_next = good_reg; // R15
        pkt_framer_pkg::RX1_FULL:   irq_b_next = full;
        pkt_framer_pkg::RX1_LEVEL:  irq_b_next = cnt_reg >= thr; // R14
        default:                    irq_b_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      host_irq_line_a_out <= 1'b0;
      host_irq_line_b_out <= 1'b0;
    end
    else
    begin
      host_irq_line_a_out <= irq_a_next;
      host_irq_line_b_out <= irq_b_next;
    end
  end

  assign fifo_count_out = cnt_reg;

  tx_off_idle_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R1
    !tx_on |=> !tx_valid_out && tx_state_reg == TX_IDLE) else $error("tx active outside packet tx mode");
  pre_four_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R10
    tx_on && tx_state_reg == TX_IDLE && tx_go && c.preamble_size == pkt_framer_pkg::PRE_4
    |=> tcnt_reg == 7'h03) else $error("preamble count wrong");
  len_discard_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R8
    rx_on && rx_state_reg == RX_LEN && rx_valid_in && rx_byte_in > {1'b0, len_max}
    |=> rx_state_reg == RX_HUNT && $stable(wp_reg)) else $error("oversize packet not discarded");
  pass_clear_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R12
    pass_clear_in && !(chk_done && crc_ok) |=> !checksum_pass_flag_out) else $error("pass flag not cleared");
  rx_level_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R14
    rx_on && c.rx_line1_source == pkt_framer_pkg::RX1_LEVEL && cnt_reg >= thr
    |=> host_irq_line_b_out) else $error("rx level event missing");
  tx_level_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R17
    tx_on && c.tx_line0_source == pkt_framer_pkg::TX0_LEVEL
    |=> host_irq_line_a_out == ($past(cnt_reg) <= $past(thr))) else $error("tx level event wrong");
  fail_clear_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R24
    clr |=> cnt_reg == 7'h00 && !rdy_reg) else $error("checksum fail kept fifo");
  depth_bound_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R13
    c.queue_depth_select == pkt_framer_pkg::DEPTH_64 && $stable(c.queue_depth_select)
    |-> cnt_reg <= 7'h40) else $error("fifo above 64 bytes");
  last_bit_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R20
    tx_on && tx_state_reg == TX_CRC_LO && slot ##1 tx_on && c.tx_line1_source == pkt_framer_pkg::TX1_LAST
    |=> host_irq_line_b_out) else $error("last bit event missing");
  rx_strip_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // R5
    rx_on && rx_valid_in && !(rx_state_reg inside {RX_LEN, RX_PAY}) |=> cnt_reg <= $past(cnt_reg))
    else $error("framing byte stored");

  tx_crc_c:  cover property (@(posedge clk_sys_in) disable iff (!resetn_in) tx_state_reg == TX_CRC_LO && slot);
  rx_pass_c: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) chk_done && crc_ok);
  rx_drop_c: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) rx_valid_in && rx_state_reg == RX_LEN && !rx_push);
  tx_cut_c:  cover property (@(posedge clk_sys_in) disable iff (!resetn_in) tx_state_reg == TX_PAY && slot && empty);
endmodule : packet_length_framer

// >>> inc/pkt_framer_pkg.sv
// shared constants, types and helpers of the packet length framer
package pkt_framer_pkg;
  localparam int         FIFO_MAX      = 64;
  localparam logic       MODE_PKT_BIT  = 1'b1;
  localparam logic       FMT_VAR       = 1'b1;
  localparam logic [6:0] EXT_LEN_MIN   = 7'h41;
  localparam logic [6:0] EXT_LEN_MAX   = 7'h7F;
  localparam logic [1:0] PRE_3         = 2'b10;
  localparam logic [1:0] PRE_4         = 2'b11;
  localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
  localparam logic [15:0] SYNC_WORD    = 16'h2DD4;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [1:0] RX1_CRC_OK    = 2'b00;
  localparam logic [1:0] RX1_FULL      = 2'b01;
  localparam logic [1:0] RX1_LEVEL     = 2'b11;
  localparam logic       TX0_LEVEL     = 1'b0;
  localparam logic       TX1_LAST      = 1'b1;
  localparam logic [1:0] DEPTH_64      = 2'b11;
  localparam logic [6:0] DEPTH_STEP    = 7'h10;

  typedef struct packed {
    logic [1:0] op_mode_select;
    logic       length_format_select;
    logic [6:0] payload_length_limit;
    logic [1:0] preamble_size;
    logic       checksum_enable;
    logic       crc_autoclear_override;
    logic [1:0] queue_depth_select;
    logic [5:0] queue_level_threshold;
    logic [1:0] rx_line1_source;
    logic       tx_line0_source;
    logic       tx_line1_source;
  } cfg_t;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc16_byte

  // fifo size in bytes: 16, 32, 48 or 64
  function automatic logic [6:0] depth_bytes(input logic [1:0] sel);
    return 7'({1'b0, sel, 4'h0}) + DEPTH_STEP;
  endfunction : depth_bytes

  function automatic logic [6:0] min7(input logic [6:0] a, input logic [6:0] b);
    return (a < b) ? a : b;
  endfunction : min7
endpackage : pkt_framer_pkg

// >>> verification/radio_side_model.sv
// radio-side model: modulator byte sink and demodulator byte source
`timescale 1ns/100ps
module radio_side_model (
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic            rx_start_out,
  output logic            rx_valid_out,
  output logic      [7:0] rx_byte_out
);
  logic [1:0] phase;

  initial
  begin
    phase        = 2'h0;
    tx_ready_out = 1'b0;
    rx_start_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_byte_out  = 8'h00;
  end

  // a stalled modulator takes at most one byte in four cycles
  always @(negedge clk_in)
  begin
    phase        <= phase + 2'h1;
    tx_ready_out <= !stall_in || (phase == 2'h0);
  end

  task automatic send_frame(input logic [7:0] b[$]);
    @(negedge clk_in);
    rx_start_out = 1'b1;
    @(negedge clk_in);
    rx_start_out = 1'b0;
    foreach (b[i])
    begin
      repeat (2) @(negedge clk_in);
      rx_valid_out = 1'b1;
      rx_byte_out  = b[i];
      @(negedge clk_in);
      rx_valid_out = 1'b0;
      // no stale byte left on the line between strobes
      rx_byte_out  = ~b[i];
    end
  endtask : send_frame
endmodule : radio_side_model

// >>> verification/test_packet_length_framer.sv
// self-checking bench of the packet length framer
`timescale 1ns/100ps
module test_packet_length_framer;
  logic                 clk_sys_in;
  logic                 resetn_in;
  pkt_framer_pkg::cfg_t cfg;
  logic                 tx_mode;
  logic                 pass_clear;
  logic                 host_wr;
  logic [7:0]           wr_data;
  logic                 host_rd;
  logic [7:0]           rd_data;
  logic [6:0]           fifo_count;
  logic                 tx_ready;
  logic                 tx_valid;
  logic [7:0]           tx_byte;
  logic                 rx_start;
  logic                 rx_valid;
  logic [7:0]           rx_byte;
  logic                 pass_flag;
  logic                 irq_a;
  logic                 irq_b;
  logic                 stall;
  logic                 rd_taken;
  logic                 rx_busy;
  logic [7:0]           tx_exp[$];
  logic [7:0]           rd_exp[$];
  logic [7:0]           rx_pl[$];
  logic [7:0]           q[$];
  int                   err_count;
  int                   comparisons;

  packet_length_framer #(.FIFO_DEPTH(64)) i_packet_length_framer (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cfg_in(cfg), .tx_mode_in(tx_mode),
    .pass_clear_in(pass_clear), .host_wr_in(host_wr), .host_wr_data_in(wr_data), .host_rd_in(host_rd),
    .host_rd_data_out(rd_data), .fifo_count_out(fifo_count), .tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
    .tx_byte_out(tx_byte), .rx_start_in(rx_start), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
    .checksum_pass_flag_out(pass_flag), .host_irq_line_a_out(irq_a), .host_irq_line_b_out(irq_b));

  radio_side_model i_radio_side_model (
    .clk_in(clk_sys_in), .stall_in(stall), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .rx_start_out(rx_start), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));

  always #50 clk_sys_in = ~clk_sys_in;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c = c ^ {b[i], 8'h00};
      for (int k = 0; k < 8; k++)
        c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction : crc_of

  // transmitted bytes are compared in order against the notes
  always @(posedge clk_sys_in)
    if (resetn_in && tx_valid && tx_ready)
      check(16'(tx_byte), (tx_exp.size() != 0) ? 16'(tx_exp.pop_front()) : 16'hFFFF);

  always @(posedge clk_sys_in)
    rd_taken <= host_rd && !tx_mode && fifo_count != 7'h00;

  always @(negedge clk_sys_in)
    if (rd_taken)
      check(16'(rd_data), (rd_exp.size() != 0) ? 16'(rd_exp.pop_front()) : 16'hFFFF);

  task automatic do_reset;
    resetn_in = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    @(negedge clk_sys_in);
  endtask : do_reset

  task automatic write_bytes(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      host_wr = 1'b1;
      wr_data = b[i];
      @(negedge clk_sys_in);
    end
    host_wr = 1'b0;
  endtask : write_bytes

  task automatic read_one;
    rd_exp.push_back(rx_pl.pop_front());
    host_rd = 1'b1;
    @(negedge clk_sys_in);
    host_rd = 1'b0;
    @(negedge clk_sys_in);
  endtask : read_one

  task automatic wait_drain(input int limit);
    int n;
    n = 0;
    while ((tx_exp.size() != 0 || rd_exp.size() != 0) && n < limit)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= limit)
    begin
      err_count++;
      final_report();
    end
  endtask : wait_drain

  task automatic tx_case(input logic fmt, input logic [1:0] pre, input logic crc, input int n, input logic src0);
    logic [7:0]  pl[$];
    logic [15:0] c;
    cfg.length_format_select  = fmt;
    cfg.preamble_size         = pre;
    cfg.checksum_enable       = crc;
    cfg.tx_line0_source       = src0;
    cfg.payload_length_limit  = 7'(n);
    cfg.queue_level_threshold = 6'(n);
    tx_mode = 1'b1;
    stall   = ~stall;
    if (fmt)
      pl.push_back(8'(n));
    repeat (n) pl.push_back(8'($urandom));
    repeat ((pre == pkt_framer_pkg::PRE_4) ? 4 : 3) tx_exp.push_back(pkt_framer_pkg::PREAMBLE_BYTE);
    tx_exp.push_back(pkt_framer_pkg::SYNC_WORD[15:8]);
    tx_exp.push_back(pkt_framer_pkg::SYNC_WORD[7:0]);
    tx_exp = {tx_exp, pl};
    c = crc_of(pl);
    if (crc)
      tx_exp = {tx_exp, c[15:8], c[7:0]};
    if (src0)
      write_bytes(pl);
    else
    begin
      // last byte held back so the fill stays below the start threshold
      write_bytes(pl[0:$-1]);
      repeat (10) @(negedge clk_sys_in);
      check(16'(tx_valid), 16'h0000);
      check(16'(irq_a), 16'h0001);
      write_bytes(pl[$:$]);
    end
    wait_drain(400);
    check(16'(irq_b), 16'h0001);
  endtask : tx_case

  task automatic rx_case(input logic fmt, input int len, input int lim, input logic good, input logic ovr,
                         input logic [1:0] src1, input logic rd_during);
    logic [7:0]  fr[$];
    logic [15:0] c;
    int          keep;
    cfg.length_format_select   = fmt;
    cfg.payload_length_limit   = 7'(lim);
    cfg.crc_autoclear_override = ovr;
    cfg.rx_line1_source        = src1;
    cfg.checksum_enable        = 1'b1;
    cfg.queue_level_threshold  = 6'h03;
    tx_mode = 1'b0;
    rx_pl = {};
    if (fmt)
      rx_pl.push_back(8'(len));
    repeat (len) rx_pl.push_back(8'($urandom));
    c    = crc_of(rx_pl) ^ (good ? 16'h0000 : 16'h0001);
    fr   = {rx_pl, c[15:8], c[7:0]};
    keep = (fmt && len > lim) ? 0 : rx_pl.size();
    rx_busy = 1'b1;
    fork
      begin
        i_radio_side_model.send_frame(fr);
        rx_busy = 1'b0;
      end
      while (rd_during && rx_busy)
      begin
        @(negedge clk_sys_in);
        if (fifo_count > 7'h01)
          read_one();
      end
    join
    repeat (4) @(negedge clk_sys_in);
    if (keep == 0 || (!good && !ovr))
    begin
      check(16'(fifo_count), 16'h0000);
      check(16'({irq_a, irq_b}), 16'h0000);
      rx_pl = {};
    end
    else
    begin
      check(16'(pass_flag), 16'(good));
      check(16'(irq_a), 16'h0001);
      if (src1 == pkt_framer_pkg::RX1_CRC_OK)
        check(16'(irq_b), 16'(good));
      if (!rd_during)
        check(16'(fifo_count), 16'(keep));
      if (src1 == pkt_framer_pkg::RX1_LEVEL)
        check(16'(irq_b), 16'(keep >= 3));
      while (rx_pl.size() != 0)
        read_one();
      wait_drain(50);
      check(16'({fifo_count, irq_a, irq_b}), 16'h0000);
      pass_clear = 1'b1;
      @(negedge clk_sys_in);
      pass_clear = 1'b0;
      @(negedge clk_sys_in);
      check(16'(pass_flag), 16'h0000);
    end
  endtask : rx_case

  initial
  begin
    clk_sys_in = 1'b0;
    resetn_in  = 1'b0;
    cfg        = '0;
    tx_mode    = 1'b1;
    pass_clear = 1'b0;
    host_wr    = 1'b0;
    wr_data    = 8'h00;
    host_rd    = 1'b0;
    stall      = 1'b0;
    rd_taken   = 1'b0;
    rx_busy    = 1'b0;
    err_count   = 0;
    comparisons = 0;
    void'($urandom(58));
    cfg.op_mode_select     = 2'b10;
    cfg.queue_depth_select = pkt_framer_pkg::DEPTH_64;
    cfg.tx_line1_source    = pkt_framer_pkg::TX1_LAST;
    do_reset();
    for (int k = 0; k < 4; k++)
      tx_case(1'b1, k[0] ? pkt_framer_pkg::PRE_4 : pkt_framer_pkg::PRE_3, k[1], 3 + k, 1'b1);
    tx_case(1'b0, pkt_framer_pkg::PRE_3, 1'b1, 4, pkt_framer_pkg::TX0_LEVEL);
    tx_case(1'b0, pkt_framer_pkg::PRE_4, 1'b0, 6, 1'b1);
    cfg.op_mode_select = 2'b11;
    rx_case(1'b1, 6, 10, 1'b1, 1'b0, pkt_framer_pkg::RX1_CRC_OK, 1'b0);
    rx_case(1'b1, 6, 10, 1'b0, 1'b0, pkt_framer_pkg::RX1_CRC_OK, 1'b0);
    rx_case(1'b1, 6, 10, 1'b0, 1'b1, pkt_framer_pkg::RX1_CRC_OK, 1'b0);
    rx_case(1'b1, 11, 10, 1'b1, 1'b0, pkt_framer_pkg::RX1_LEVEL, 1'b0);
    rx_case(1'b0, 5, 5, 1'b1, 1'b0, pkt_framer_pkg::RX1_LEVEL, 1'b0);
    rx_case(1'b1, 68, 70, 1'b1, 1'b0, pkt_framer_pkg::RX1_CRC_OK, 1'b1);
    // outside packet mode the fifo fills to its depth and nothing is framed
    cfg.op_mode_select = 2'b01;
    tx_mode = 1'b1;
    repeat (66) q.push_back(8'($urandom));
    write_bytes(q);
    repeat (3) @(negedge clk_sys_in);
    check(16'(fifo_count), 16'h0040);
    check(16'({tx_valid, irq_a, irq_b}), 16'h0000);
    do_reset();
    check(16'(fifo_count), 16'h0000);
    final_report();
  end
endmodule : test_packet_length_framer
